//--- pioc_pkg.sv
// package for the programmable i/o cell: register map, field layouts,
// mode encodings and reset values.
// assumes a single 32-bit register word per offset on the plain port.
package pioc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  OFF_CTRL    = 4'h0;
  localparam logic [3:0]  OFF_IN_CFG  = 4'h4;
  localparam logic [3:0]  OFF_OUT_CFG = 4'h8;
  localparam logic [3:0]  OFF_STATUS  = 4'hc;

  // ctrl word
  localparam int          CTRL_DONE_BIT = 0;

  // status word bit positions
  localparam int ST_DONE   = 0;
  localparam int ST_ZH_OK  = 1;
  localparam int ST_PAD    = 2;
  localparam int ST_IN_Q   = 3;
  localparam int ST_FZ_LAT = 4;
  localparam int ST_OUT_Q  = 5;
  localparam int ST_TS_Q   = 6;
  localparam int ST_PAD_O  = 7;
  localparam int ST_OE_B   = 8;

  // ------------------------------------------------------------------
  // mode encodings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_DIRECT, IN_LATCH, IN_FF, IN_FAST_ZH
  } pioc_in_mode_e;
  typedef enum logic [1:0] {PULL_UP, PULL_DOWN, PULL_NONE} pioc_pull_e;
  typedef enum logic [1:0] {SPD_FAST, SPD_SLEWLIM, SPD_SINKLIM} pioc_speed_e;
  typedef enum logic [1:0] {SRC_FIRST, SRC_SECOND, SRC_HIGH, SRC_LOW} pioc_src_e;
  typedef enum logic [1:0] {CE_HIGH, CE_LOW, CE_ALWAYS} pioc_ce_e;
  typedef enum logic [1:0] {TS_HIGH, TS_LOW, TS_ALWAYS} pioc_ts_e;
  typedef enum logic [2:0] {
    PAD_ROUTE_FIRST, PAD_ROUTE_SECOND, PAD_FLOP,
    PAD_DIRECT_PHASE, PAD_REG_MUX_FIRST, PAD_REG_MUX_SECOND
  } pioc_pad_sel_e;

  // ------------------------------------------------------------------
  // configuration words (first field is the most significant)
  // ------------------------------------------------------------------
  typedef struct packed {
    pioc_pull_e    pull;
    logic          ce_always;
    logic          lsr_over_ce;
    logic          ce_inv;
    logic          gsr_en;
    logic          lsr_val;
    logic          lsr_sync;
    logic          lsr_inv;
    logic          lsr_en;
    logic          swap;
    logic          spine_sel;
    logic          clk_inv;
    logic          delay_en;
    pioc_in_mode_e mode;
  } pioc_in_cfg_s;

  typedef struct packed {
    pioc_speed_e   speed;
    logic          open_drain;
    logic          ts_reg;
    pioc_ts_e      ts_mode;
    logic          out_inv;
    pioc_pad_sel_e pad_sel;
    logic          lsr_over_ce;
    pioc_ce_e      ce_mode;
    logic          gsr_en;
    logic          lsr_val;
    logic          lsr_sync;
    logic          lsr_inv;
    logic          lsr_en;
    logic          clk_inv;
    logic          clk_sel;
    logic          d_inv;
    pioc_src_e     src;
  } pioc_out_cfg_s;

  localparam int            IN_CFG_W    = $bits(pioc_in_cfg_s);
  localparam int            OUT_CFG_W   = $bits(pioc_out_cfg_s);
  localparam pioc_in_cfg_s  IN_CFG_RST  = pioc_in_cfg_s'(0);
  localparam pioc_out_cfg_s OUT_CFG_RST = pioc_out_cfg_s'(0);

  // fabric-side signals
  typedef struct packed {
    logic out_first;
    logic out_second;
    logic tristate;
    logic in_clk_en;
    logic out_clk_en;
    logic local_set_reset;
    logic gsr_b;
  } pioc_fabric_s;

endpackage

//--- pioc_cell.sv
// programmable i/o cell datapath: input capture and demultiplexing,
// output flop with phase multiplexing, 3-state and open-drain control.
// assumes pad and cell clocks arrive asynchronously to sys_clk_i and
// are oversampled; fabric signals are on sys_clk_i.
//
// What this block does
// - delayed input is captured by flop or latch on the system clock
// - zero-hold guaranteed only when the spine clock source is selected
// - fast zero-hold: fast-clock latch feeds the system-clock input flop
// - demux: pad goes to input register and straight to second path
// - latch holds at falling edge, feeds first path for next rising edge
// - demux register may be flop instead of latch; paths can swap
// - before configuration: slew-limited outputs, input pull-up on
// - an output not driven by configuration stays high impedance
// - output data invertible; enable active-high, active-low or always
// - 3-state control registered or combinational by configuration
// - open drain: data drives enable, pad only low or released
// - two fabric outputs both reach the output data logic
// - output flop has local set/reset, sync or async, and clock enable
// - clock enable over set/reset or set/reset over clock enable
// - output flop clocked by system clock or fast edge clock
// - output flop data: first, second, high or low, optional invert
// - direct phase mux: first while clock low, second while high
// - registered mux: flop value shown in phase after active edge
// - second-path mux: first registered; flop high phase, second low
// - input register: clock sense, set/reset sense, priority, global
// - input delay acts on both routing paths, not the clock route
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pioc_cell
  import pioc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // pad and cell clocks, asynchronous
  input  wire logic              pad_i,
  input  wire logic              spine_clk_i,
  input  wire logic              general_clk_i,
  input  wire logic              fast_edge_clock_i,
  output logic                   pad_o,
  output logic                   pad_oe_b_o,
  output logic                   pull_up_o,
  output logic                   pull_down_o,
  output pioc_speed_e            slew_mode_o,
  // fabric side
  input  wire pioc_fabric_s      fabric_i,
  output logic                   route_in_first_o,
  output logic                   route_in_second_o,
  output logic                   clock_route_o
);

  // ------------------------------------------------------------------
  // shared register update
  // ------------------------------------------------------------------
  // one cell register: global set/reset, local set/reset with priority
  // against clock enable, synchronous or immediate
  function automatic logic reg_next(input logic q,
                                    input logic d,
                                    input logic edge_ok,
                                    input logic ce,
                                    input logic local_set_reset,
                                    input logic sync,
                                    input logic lsr_over,
                                    input logic val,
                                    input logic global_set_reset);
    logic lsr_ok;
    lsr_ok = local_set_reset && (lsr_over || ce);
    if (global_set_reset)
      return val;
    if (lsr_ok && !sync)
      return val;
    if (edge_ok && lsr_ok)
      return val;
    if (edge_ok && ce)
      return d;
    return q;
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic          done;
  pioc_in_cfg_s  in_cfg;
  pioc_out_cfg_s out_cfg;
  logic [DATA_W-1:0] status;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done    <= 1'b0;
      in_cfg  <= IN_CFG_RST;
      out_cfg <= OUT_CFG_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFF_CTRL:    done    <= reg_wdata_i[CTRL_DONE_BIT];
        OFF_IN_CFG:  in_cfg  <= pioc_in_cfg_s'(reg_wdata_i[IN_CFG_W-1:0]);
        OFF_OUT_CFG: out_cfg <= pioc_out_cfg_s'(reg_wdata_i[OUT_CFG_W-1:0]);
        default: ;
      endcase
    end
  end

  // unmapped offsets read as zero, and read data is zero in cycles without a read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFF_CTRL:    reg_rdata_o <= DATA_W'(done);
        OFF_IN_CFG:  reg_rdata_o <= DATA_W'(in_cfg);
        OFF_OUT_CFG: reg_rdata_o <= DATA_W'(out_cfg);
        OFF_STATUS:  reg_rdata_o <= status;
        default:     reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ------------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------------
  // order: pad, spine, general, fast
  logic [3:0] sync_a;
  logic [3:0] sync_b;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {fast_edge_clock_i, general_clk_i, spine_clk_i, pad_i};
      sync_b <= sync_a;
    end
  end

  logic pad_s;
  logic fast_s;
  logic sys_sel;
  assign pad_s   = sync_b[0];
  assign fast_s  = sync_b[3];
  assign sys_sel = in_cfg.spine_sel ? sync_b[1] : sync_b[2];

  // ------------------------------------------------------------------
  // clock edges
  // ------------------------------------------------------------------
  logic in_clk;
  logic in_clk_q;
  logic in_rise;
  logic out_clk;
  logic out_clk_q;
  logic out_rise;

  assign in_clk  = sys_sel ^ in_cfg.clk_inv;
  assign out_clk = (out_cfg.clk_sel ? fast_s : sys_sel)
                   ^ out_cfg.clk_inv;
  assign in_rise  = in_clk & ~in_clk_q;
  assign out_rise = out_clk & ~out_clk_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_clk_q  <= 1'b0;
      out_clk_q <= 1'b0;
    end else begin
      in_clk_q  <= in_clk;
      out_clk_q <= out_clk;
    end
  end

  // ------------------------------------------------------------------
  // input path
  // ------------------------------------------------------------------
  // the delay stage trades setup time for zero hold, guaranteed only with the spine clock and a registered input mode
  logic pad_dly;
  logic route_data;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      pad_dly <= 1'b0;
    else
      pad_dly <= pad_s;
  end

  assign route_data = in_cfg.delay_en ? pad_dly : pad_s;

  logic in_lsr;
  logic in_gsr;
  logic in_ce;
  logic in_edge;
  logic in_d;
  logic in_q;
  logic fz_latch;

  assign in_lsr = in_cfg.lsr_en & (fabric_i.local_set_reset ^ in_cfg.lsr_inv);
  assign in_gsr = in_cfg.gsr_en & ~fabric_i.gsr_b;
  // clock enable is meaningless for a latch
  assign in_ce  = (in_cfg.mode == IN_LATCH) | in_cfg.ce_always
                | (fabric_i.in_clk_en ^ in_cfg.ce_inv);
  // latch is open while its clock is high, so it holds from the fall
  assign in_edge = (in_cfg.mode == IN_LATCH) ? in_clk : in_rise;
  assign in_d    = (in_cfg.mode == IN_FAST_ZH) ? fz_latch
                                               : route_data;

  // fast capture latch open while the fast edge clock is high
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      fz_latch <= 1'b0;
    else if (fast_s)
      fz_latch <= route_data;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      in_q <= 1'b0;
    else if (in_cfg.mode != IN_DIRECT)
      in_q <= reg_next(in_q, in_d, in_edge, in_ce, in_lsr,
                       in_cfg.lsr_sync, in_cfg.lsr_over_ce,
                       in_cfg.lsr_val, in_gsr);
  end

  logic first_raw;
  logic second_raw;
  logic zh_ok;

  assign first_raw  = (in_cfg.mode == IN_DIRECT) ? route_data : in_q;
  assign second_raw = route_data;
  assign zh_ok = in_cfg.spine_sel
               & ((in_cfg.delay_en & (in_cfg.mode != IN_DIRECT))
                  | (in_cfg.mode == IN_FAST_ZH));

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_in_first_o  <= 1'b0;
      route_in_second_o <= 1'b0;
      clock_route_o     <= 1'b0;
    end else begin
      route_in_first_o  <= in_cfg.swap ? second_raw : first_raw;
      route_in_second_o <= in_cfg.swap ? first_raw : second_raw;
      clock_route_o     <= pad_s;
    end
  end

  // ------------------------------------------------------------------
  // output flop and 3-state flop
  // ------------------------------------------------------------------
  logic out_lsr;
  logic out_gsr;
  logic out_ce;
  logic out_d;
  logic out_q;
  logic ts_raw;
  logic ts_q;

  assign out_lsr = out_cfg.lsr_en
                 & (fabric_i.local_set_reset ^ out_cfg.lsr_inv);
  assign out_gsr = out_cfg.gsr_en & ~fabric_i.gsr_b;

  always_comb begin
    unique case (out_cfg.ce_mode)
      CE_HIGH: out_ce = fabric_i.out_clk_en;
      CE_LOW:  out_ce = ~fabric_i.out_clk_en;
      default: out_ce = 1'b1;
    endcase
  end

  always_comb begin
    unique case (out_cfg.src)
      SRC_FIRST:  out_d = fabric_i.out_first;
      SRC_SECOND: out_d = fabric_i.out_second;
      SRC_HIGH:   out_d = 1'b1;
      default:    out_d = 1'b0;
    endcase
    if (out_cfg.pad_sel == PAD_REG_MUX_SECOND)
      out_d = fabric_i.out_first;
    out_d = out_d ^ out_cfg.d_inv;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      out_q <= 1'b0;
    else
      out_q <= reg_next(out_q, out_d, out_rise, out_ce, out_lsr,
                        out_cfg.lsr_sync, out_cfg.lsr_over_ce,
                        out_cfg.lsr_val, out_gsr);
  end

  always_comb begin
    unique case (out_cfg.ts_mode)
      TS_HIGH: ts_raw = fabric_i.tristate;
      TS_LOW:  ts_raw = ~fabric_i.tristate;
      default: ts_raw = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      ts_q <= 1'b0;
    else
      ts_q <= reg_next(ts_q, ts_raw, out_rise, out_ce, out_lsr,
                       out_cfg.lsr_sync, out_cfg.lsr_over_ce,
                       out_cfg.lsr_val, out_gsr);
  end

  // ------------------------------------------------------------------
  // pad multiplexing and drive
  // ------------------------------------------------------------------
  logic mux_data;
  logic pad_data;
  logic drive_en;
  logic next_pad;
  logic next_oe_b;

  // phase mux follows the sampled clock level, so each half period is
  // seen two system cycles late; this bounds the usable cell clock rate
  always_comb begin
    unique case (out_cfg.pad_sel)
      PAD_ROUTE_FIRST:    mux_data = fabric_i.out_first;
      PAD_ROUTE_SECOND:   mux_data = fabric_i.out_second;
      PAD_FLOP:           mux_data = out_q;
      PAD_DIRECT_PHASE:   mux_data = out_clk ? fabric_i.out_second
                                             : fabric_i.out_first;
      PAD_REG_MUX_FIRST:  mux_data = out_clk ? out_q
                                             : fabric_i.out_first;
      PAD_REG_MUX_SECOND: mux_data = out_clk ? out_q
                                             : fabric_i.out_second;
      default:            mux_data = 1'b0;
    endcase
  end

  assign pad_data = mux_data ^ out_cfg.out_inv;

  always_comb begin
    if (!done) begin
      next_pad = 1'b0;
      drive_en = 1'b0;
    end else if (out_cfg.open_drain) begin
      next_pad = 1'b0;
      drive_en = ~pad_data;
    end else begin
      next_pad = pad_data;
      drive_en = out_cfg.ts_reg ? ts_q : ts_raw;
    end
    next_oe_b = ~drive_en;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_o       <= 1'b0;
      pad_oe_b_o  <= 1'b1;
      pull_up_o   <= 1'b1;
      pull_down_o <= 1'b0;
      slew_mode_o <= SPD_SLEWLIM;
    end else begin
      pad_o       <= next_pad;
      pad_oe_b_o  <= next_oe_b;
      pull_up_o   <= ~done | (in_cfg.pull == PULL_UP);
      pull_down_o <= done & (in_cfg.pull == PULL_DOWN);
      slew_mode_o <= done ? out_cfg.speed : SPD_SLEWLIM;
    end
  end

  // ------------------------------------------------------------------
  // status
  // ------------------------------------------------------------------
  always_comb begin
    status            = '0;
    status[ST_DONE]   = done;
    status[ST_ZH_OK]  = zh_ok;
    status[ST_PAD]    = pad_s;
    status[ST_IN_Q]   = in_q;
    status[ST_FZ_LAT] = fz_latch;
    status[ST_OUT_Q]  = out_q;
    status[ST_TS_Q]   = ts_q;
    status[ST_PAD_O]  = pad_o;
    status[ST_OE_B]   = pad_oe_b_o;
  end

endmodule

`default_nettype wire

//--- pioc_pad_model.sv
// pad and cell clock model for the programmable i/o cell bench.
// assumes the bench commands the cell clock level and any outside driver.
`timescale 1ns/1ps
`default_nettype none

module pioc_pad_model (
  input  wire logic sys_clk_i,
  input  wire logic cell_clk_i,
  input  wire logic ext_en_i,
  input  wire logic ext_val_i,
  input  wire logic data_i,
  input  wire logic oe_b_i,
  input  wire logic pu_i,
  input  wire logic pd_i,
  output logic      pad_o,
  output logic      spine_o,
  output logic      general_o,
  output logic      fast_o
);
  logic wander = 1'b0;

  // ----------
  // pad wire
  // ----------
  // a floating pad keeps changing so a stale value never looks valid
  always @(posedge sys_clk_i) wander <= !wander;

  always_comb begin
    if (!oe_b_i)       pad_o = data_i;
    else if (ext_en_i) pad_o = ext_val_i;
    else if (pu_i)     pad_o = 1'b1;
    else if (pd_i)     pad_o = 1'b0;
    else               pad_o = wander;
  end

  // ----------
  // cell clocks
  // ----------
  // one waveform on every source, so any clock selection sees the edges
  assign spine_o   = cell_clk_i;
  assign general_o = cell_clk_i;
  assign fast_o    = cell_clk_i;
endmodule

`default_nettype wire

//--- pioc_cell_monitor.sv
// port checker for the programmable i/o cell.
// assumes it is bound to pioc_cell and shadows config from the port writes.
`timescale 1ns/1ps
`default_nettype none

module pioc_cell_monitor
  import pioc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_rdata_o,
  input  wire pioc_fabric_s      fabric_i,
  input  wire logic              pad_o,
  input  wire logic              pad_oe_b_o,
  input  wire logic              pull_up_o,
  input  wire logic              pull_down_o,
  input  wire pioc_speed_e       slew_mode_o
);
  logic          sh_done;
  pioc_in_cfg_s  sh_in;
  pioc_out_cfg_s sh_out;
  logic          wr_q;
  logic          settled;
  logic          early;

  // ----------
  // config shadow
  // ----------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_done <= 1'b0;
      sh_in   <= IN_CFG_RST;
      sh_out  <= OUT_CFG_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFF_CTRL)
        sh_done <= reg_wdata_i[CTRL_DONE_BIT];
      if (reg_addr_i == OFF_IN_CFG)
        sh_in <= reg_wdata_i[IN_CFG_W-1:0];
      if (reg_addr_i == OFF_OUT_CFG)
        sh_out <= reg_wdata_i[OUT_CFG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      wr_q <= 1'b0;
    else
      wr_q <= reg_wr_i;
  end

  // outputs are registered, so skip the cycle right after a write
  assign settled = sh_done && !wr_q;
  assign early   = !sh_done;

  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_rdata_idle_zero: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero when idle");
  a_early_pad_released: assert property (early |-> pad_oe_b_o)
    else $error("pad driven before config");
  a_early_pull_up: assert property (
    early |-> pull_up_o && !pull_down_o)
    else $error("pull-up off before config");
  a_early_slew_limit: assert property (
    early |-> slew_mode_o == SPD_SLEWLIM)
    else $error("speed not slewlim before config");
  a_od_never_high: assert property (
    settled && sh_out.open_drain |-> pad_oe_b_o || !pad_o)
    else $error("open drain pad driven high");
  a_speed_follows: assert property (
    settled |-> slew_mode_o == sh_out.speed)
    else $error("speed not as configured");
  a_pull_follows: assert property (
    settled |-> pull_up_o == (sh_in.pull == PULL_UP)
    && pull_down_o == (sh_in.pull == PULL_DOWN))
    else $error("pulls not as configured");
  a_ts_sense_map: assert property (
    settled && sh_out.pad_sel == PAD_ROUTE_FIRST && !sh_out.open_drain
    && !sh_out.ts_reg |-> pad_oe_b_o == (sh_out.ts_mode != TS_ALWAYS
    && ($past(fabric_i.tristate) ^ (sh_out.ts_mode == TS_HIGH))))
    else $error("enable not as 3-state control");
  a_route_data_inv: assert property (
    settled && sh_out.pad_sel == PAD_ROUTE_FIRST && !sh_out.open_drain
    && sh_out.ts_mode == TS_ALWAYS
    |-> pad_o == ($past(fabric_i.out_first) ^ sh_out.out_inv))
    else $error("pad data not first fabric output");

  c_phase_mux: cover property (settled && sh_out.pad_sel == PAD_DIRECT_PHASE);
  c_od_drive: cover property (settled && sh_out.open_drain && !pad_oe_b_o);
  c_read_answer: cover property ($past(reg_rd_i) && reg_rdata_o != '0);
endmodule

bind pioc_cell pioc_cell_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .fabric_i(fabric_i), .pad_o(pad_o),
  .pad_oe_b_o(pad_oe_b_o), .pull_up_o(pull_up_o),
  .pull_down_o(pull_down_o), .slew_mode_o(slew_mode_o));

`default_nettype wire

//--- pioc_cell_tb.sv
// self-checking bench for the programmable i/o cell.
// assumes the pad model stands on the pad side; fabric is driven here.
`timescale 1ns/1ps
`default_nettype none

module pioc_cell_tb
  import pioc_pkg::*;
;
  typedef struct packed {
    logic [23:0] cfg;
    logic [6:0]  fab;
    logic        edg;
    logic        lvl;
    logic        o;
    logic        oe_b;
  } pioc_row_s;

  localparam int NROW = 32;
  // out_cfg, fabric, edge, final clock level, pad data, pad enable
  localparam pioc_row_s ROWS [NROW] = '{
    {24'h040000,7'h41,4'h2},{24'h042000,7'h21,4'h2},
    {24'h050000,7'h41,4'h0},{24'h000000,7'h51,4'h2},
    {24'h000000,7'h41,4'h1},{24'h020000,7'h51,4'h1},
    {24'h020000,7'h41,4'h2},{24'h140000,7'h41,4'h1},
    {24'h140000,7'h01,4'h0},{24'h044800,7'h41,4'ha},
    {24'h044801,7'h41,4'h8},{24'h044802,7'h01,4'ha},
    {24'h044807,7'h01,4'ha},{24'h044803,7'h01,4'h8},
    {24'h044802,7'h01,4'h0},{24'h04480a,7'h01,4'ha},
    {24'h044822,7'h03,4'h0},{24'h044802,7'h01,4'ha},
    {24'h0448a2,7'h03,4'h2},{24'h0448a2,7'h03,4'h8},
    {24'h044802,7'h01,4'ha},{24'h044022,7'h03,4'h2},
    {24'h045022,7'h03,4'h0},{24'h046000,7'h41,4'h2},
    {24'h046000,7'h41,4'h4},{24'h046000,7'h21,4'h0},
    {24'h046000,7'h21,4'h6},{24'h04a800,7'h41,4'he},
    {24'h04a800,7'h21,4'h2},{24'h04a800,7'h21,4'hc},
    {24'h048801,7'h41,4'ha},{24'h048801,7'h41,4'h4}};

  logic              sys_clk_i   = 1'b0;
  logic              rst_b_i     = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i  = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i    = 1'b0;
  logic              reg_rd_i    = 1'b0;
  pioc_fabric_s      fabric_i    = '0;
  logic              cell_clk    = 1'b0;
  logic              ext_en      = 1'b0;
  logic              ext_val     = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              pad_i;
  logic              spine_clk;
  logic              general_clk;
  logic              fast_clk;
  logic              pad_o;
  logic              pad_oe_b_o;
  logic              pull_up_o;
  logic              pull_down_o;
  pioc_speed_e       slew_mode_o;
  logic              route_in_first_o;
  logic              route_in_second_o;
  logic              clock_route_o;
  int                fail_count      = 0;
  int                samples_checked = 0;

  always #10 sys_clk_i = !sys_clk_i;

  pioc_cell dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pad_i(pad_i), .spine_clk_i(spine_clk),
    .general_clk_i(general_clk), .fast_edge_clock_i(fast_clk),
    .pad_o(pad_o), .pad_oe_b_o(pad_oe_b_o), .pull_up_o(pull_up_o),
    .pull_down_o(pull_down_o), .slew_mode_o(slew_mode_o),
    .fabric_i(fabric_i), .route_in_first_o(route_in_first_o),
    .route_in_second_o(route_in_second_o), .clock_route_o(clock_route_o));

  pioc_pad_model u_pad (
    .sys_clk_i(sys_clk_i), .cell_clk_i(cell_clk), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .data_i(pad_o), .oe_b_i(pad_oe_b_o),
    .pu_i(pull_up_o), .pd_i(pull_down_o), .pad_o(pad_i),
    .spine_o(spine_clk), .general_o(general_clk), .fast_o(fast_clk));

  // ----------
  // helpers
  // ----------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ends one step past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // cell clock levels are held long enough for the oversampler
  task automatic set_clk(input logic v);
    @(posedge sys_clk_i);
    cell_clk <= v;
    wt(8);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    logic [DATA_W-1:0] d;
    logic              rg;
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      rd(ADDR_W'(a), d);
      chk("config reset", 32'h0, d);
    end
    rd(OFF_STATUS, d);
    chk("status reset", 32'h100, d & 32'h101);
    wr(OFF_OUT_CFG, 32'h440000);
    wt(8);
    chk("early enable", 32'h1, 32'(pad_oe_b_o));
    chk("early pull", 32'h1, 32'(pull_up_o));
    chk("early speed", 32'(SPD_SLEWLIM), 32'(slew_mode_o));
    wr(4'h2, 32'hffffffff);
    rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    rd(OFF_OUT_CFG, d);
    chk("out cfg", 32'h440000, d);
    wr(OFF_STATUS, 32'hffffffff);
    rd(OFF_STATUS, d);
    chk("status ro", 32'h0, d & 32'h1);
    wr(OFF_CTRL, 32'h1);
    wt(8);
    chk("speed", 32'(SPD_SINKLIM), 32'(slew_mode_o));
    $display("test registers done");

    for (int i = 0; i < NROW; i++) begin
      set_clk(1'b0);
      wr(OFF_OUT_CFG, {8'h00, ROWS[i].cfg});
      fabric_i <= ROWS[i].fab;
      wt(8);
      if (ROWS[i].edg) set_clk(1'b1);
      set_clk(ROWS[i].lvl);
      chk("pad_oe_b_o", 32'(ROWS[i].oe_b), 32'(pad_oe_b_o));
      if (!ROWS[i].oe_b)
        chk("pad_o", 32'(ROWS[i].o),
            32'(pad_o));
    end
    $display("test output rows done");

    wr(OFF_OUT_CFG, 32'h0);
    fabric_i <= 7'h0d;
    ext_en   <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        wr(OFF_IN_CFG, 32'(s * 32'h4020 + m * 5 % 8 + 32'h10));
        @(posedge sys_clk_i);
        ext_val <= 1'b1;
        set_clk(1'b1);
        chk("clock route", 32'h1, 32'(clock_route_o));
        set_clk(1'b0);
        set_clk(1'b1);
        set_clk(1'b0);
        @(posedge sys_clk_i);
        ext_val <= 1'b0;
        wt(8);
        rg = (m != 0);
        chk("route first", 32'(s ? 1'b0 : rg),
            32'(route_in_first_o));
        chk("route second", 32'(s ? rg : 1'b0),
            32'(route_in_second_o));
      end
    end
    $display("test input modes done");

    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    wt(2);
    chk("reset enable", 32'h1, 32'(pad_oe_b_o));
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(OFF_CTRL, d);
    chk("ctrl after reset", 32'h0, d);
    $display("test second reset done");
    finish_test();
  end
endmodule

`default_nettype wire
